//--- design/drive_enable_stop_sequencer.sv
// drive enable / stop sequencer with axi4-lite registers
// Summary of operation
// R1: fault clear input clears resettable faults
// R2: persisting cause raises same fault again
// R3: major faults ignore clear, power cycle only
// R4: health contact closed unless a fault present
// R5: user output chosen by configuration parameter
// R6: permits accepted in either order
// R7: controller waits for soft start before enables
// R8: torque only with power permit and bus
// R9: velocity command followed only with both permits
// R10: power permit is and of three requests
// R11: power permit loss removes torque at once
// R12: speed permit loss zeroes command, keeps torque
// R13: standstill in time sets flag, drops torque
// R14: stop limit expiry drops torque, motor coasts
// R15: hardware permit cuts power without software
// R16: inputs synchronised, stop limit counted in ticks
`timescale 1ns/10ps
`default_nettype none
module drive_enable_stop_sequencer #(
  parameter int vel_width = 16, // velocity command width
  parameter int tick_len = drive_seq_pkg::tick_cycles, // cycles per ms tick
  parameter int fault_width = 8 // fault cause lines per class
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // control pins from the controller
  input wire logic drive_enable_pin,
  input wire logic speed_enable_pin,
  input wire logic fault_reset_pin,
  input wire logic bus_voltage_ok, // power bus present, from bus monitor
  input wire logic motor_at_rest, // speed below standstill threshold
  input wire logic [fault_width-1:0] resettable_cause, // live resettable conditions
  input wire logic [fault_width-1:0] major_cause, // live major conditions
  input wire logic [vel_width-1:0] velocity_cmd_in, // external command
  // outputs
  output logic [vel_width-1:0] velocity_cmd, // internal command
  output logic torque_enable, // power stage gate
  output logic health_status_contact, // closed = high
  output logic user_output_contact,
  output logic standstill_flag,
  output logic irq
);
  // synchronised control pins
  drive_seq_pkg::ctrl_pins_t pins;
  logic [3:0] pins_raw;

  // all pins cross into aclk through two flops
  assign pins_raw = {drive_enable_pin, speed_enable_pin, fault_reset_pin, bus_voltage_ok};
  pin_sync #(.width(4)) u_sync ( // [R16]
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(pins_raw),
    .sync_out(pins)
  );

  // fault sources are internal monitors; sampled through two flops as well to share timing
  logic [fault_width-1:0] res_s1, res_s2, maj_s1, maj_s2;
  logic rest_s1, rest_s2;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_s1 <= '0;
      res_s2 <= '0;
      maj_s1 <= '0;
      maj_s2 <= '0;
      rest_s1 <= 1'b0;
      rest_s2 <= 1'b0;
    end else begin
      res_s1 <= resettable_cause;
      res_s2 <= res_s1;
      maj_s1 <= major_cause;
      maj_s2 <= maj_s1;
      rest_s1 <= motor_at_rest;
      rest_s2 <= rest_s1;
    end
  end

  // register state
  logic sw_permit, plc_permit, fault_clr_pulse;
  logic [2:0] user_sel;
  logic [15:0] stop_limit;
  localparam int ev_w = drive_seq_pkg::ev_width;
  logic [ev_w-1:0] irq_status, irq_mask;
  logic [fault_width-1:0] sw_res_fault, sw_maj_fault; // software-injected conditions
  logic [fault_width-1:0] res_latch, maj_latch; // latched faults

  // effective permit: and of three requests
  logic power_permit;
  assign power_permit = pins.drive_en & sw_permit & plc_permit; // [R10]

  // fault latches; set wins over clear
  logic [fault_width-1:0] next_res_latch, next_maj_latch;
  logic clear_req;
  always_comb begin
    clear_req = pins.fault_clr | fault_clr_pulse;
    next_res_latch = res_latch;
    if (clear_req) begin
      next_res_latch = '0; // [R1]
    end
    next_res_latch = next_res_latch | res_s2 | sw_res_fault; // [R2]
    next_maj_latch = maj_latch | maj_s2 | sw_maj_fault; // [R3] no clear path
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_latch <= '0;
      maj_latch <= '0;
    end else begin
      res_latch <= next_res_latch;
      maj_latch <= next_maj_latch;
    end
  end

  logic any_fault;
  assign any_fault = (|res_latch) | (|maj_latch);

  // stop sequence; the enables may arrive in any order [R6]
  drive_seq_pkg::stop_state_t state, next_state;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic [15:0] ms_cnt, next_ms_cnt;
  logic ev_standstill, ev_timeout;
  always_comb begin
    next_state = state;
    next_tick_cnt = tick_cnt;
    next_ms_cnt = ms_cnt;
    ev_standstill = 1'b0;
    ev_timeout = 1'b0;
    // controller is trusted to hold enables until soft start is done [R7]
    unique case (state)
      drive_seq_pkg::st_off: begin
        if (power_permit && pins.bus_ok && !any_fault) begin
          next_state = drive_seq_pkg::st_run;
        end
      end
      drive_seq_pkg::st_run: begin
        if (!pins.speed_en) begin
          next_state = drive_seq_pkg::st_braking; // [R12]
          next_tick_cnt = '0;
          next_ms_cnt = '0;
        end
      end
      drive_seq_pkg::st_braking: begin
        if (rest_s2) begin
          next_state = drive_seq_pkg::st_free; // [R13]
          ev_standstill = 1'b1;
        end else if (ms_cnt >= stop_limit) begin
          next_state = drive_seq_pkg::st_free; // [R14]
          ev_timeout = 1'b1;
        end else if (tick_cnt == 32'(tick_len - 1)) begin
          next_tick_cnt = '0; // [R16]
          next_ms_cnt = ms_cnt + 16'h0001;
        end else begin
          next_tick_cnt = tick_cnt + 32'h0000_0001;
        end
      end
      drive_seq_pkg::st_free: begin
        if (pins.speed_en) begin
          next_state = drive_seq_pkg::st_run;
        end
      end
    endcase
    // loss of power permit, bus or a fault overrides everything
    if (!power_permit || !pins.bus_ok || any_fault) begin
      next_state = drive_seq_pkg::st_off; // [R11]
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= drive_seq_pkg::st_off;
      tick_cnt <= '0;
      ms_cnt <= '0;
    end else begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      ms_cnt <= next_ms_cnt;
    end
  end

  // outputs; torque gated combinationally by the hardware pin so no register
  // or software path can hold the power stage on
  logic torque_state, follow;
  assign torque_state = (state == drive_seq_pkg::st_run) || (state == drive_seq_pkg::st_braking);
  assign torque_enable = torque_state & power_permit & pins.bus_ok; // [R8] [R15]
  assign follow = (state == drive_seq_pkg::st_run) && pins.speed_en; // [R9]

  logic [vel_width-1:0] next_velocity_cmd;
  logic next_standstill, user_mux;
  always_comb begin
    next_velocity_cmd = follow ? velocity_cmd_in : '0; // [R9] [R12]
    next_standstill = standstill_flag;
    if (ev_standstill) begin
      next_standstill = 1'b1; // [R13]
    end else if (state != drive_seq_pkg::st_free && state != drive_seq_pkg::st_braking) begin
      next_standstill = 1'b0;
    end
    unique case (user_sel)
      drive_seq_pkg::sel_torque: user_mux = torque_enable;
      drive_seq_pkg::sel_standstill: user_mux = standstill_flag;
      drive_seq_pkg::sel_vel_follow: user_mux = follow;
      drive_seq_pkg::sel_any_fault: user_mux = any_fault;
      default: user_mux = !any_fault; // health and unused codes
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      velocity_cmd <= '0;
      standstill_flag <= 1'b0;
      health_status_contact <= 1'b0;
      user_output_contact <= 1'b0;
    end else begin
      velocity_cmd <= next_velocity_cmd;
      standstill_flag <= next_standstill;
      health_status_contact <= !any_fault; // [R4]
      user_output_contact <= user_mux; // [R5]
    end
  end

  // axi4-lite write: take address and data in either order
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  logic do_write;
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) old[i*8 +: 8] = d[i*8 +: 8];
    end
    return old;
  endfunction : merge

  logic [31:0] ctl_word, cfg_word, lim_word, mask_word, flt_word, wv, cur;
  assign ctl_word = {29'h0, 1'b0, plc_permit, sw_permit};
  assign cfg_word = {29'h0, user_sel};
  assign lim_word = {16'h0, stop_limit};
  assign mask_word = {28'h0, irq_mask};
  assign flt_word = {16'h0, sw_maj_fault, sw_res_fault};

  // addressed register as it stands, merged with the strobed write bytes
  always_comb begin
    unique case (aw_addr)
      drive_seq_pkg::off_control: cur = ctl_word;
      drive_seq_pkg::off_config: cur = cfg_word;
      drive_seq_pkg::off_stop_limit: cur = lim_word;
      drive_seq_pkg::off_irq_mask: cur = mask_word;
      drive_seq_pkg::off_fault_in: cur = flt_word;
      default: cur = w_data;
    endcase
    wv = merge(cur, w_data, w_strb);
  end

  logic [ev_w-1:0] events, next_irq_status;
  assign events = {ev_timeout, ev_standstill, torque_state && next_state == drive_seq_pkg::st_off,
                   (|(next_res_latch & ~res_latch)) | (|(next_maj_latch & ~maj_latch))};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= drive_seq_pkg::resp_okay;
      sw_permit <= 1'b0;
      plc_permit <= 1'b0;
      fault_clr_pulse <= 1'b0;
      user_sel <= drive_seq_pkg::user_sel_reset;
      stop_limit <= drive_seq_pkg::stop_limit_reset;
      irq_mask <= '0;
      irq_status <= '0;
      sw_res_fault <= '0;
      sw_maj_fault <= '0;
    end else begin
      fault_clr_pulse <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      irq_status <= next_irq_status;
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= drive_seq_pkg::resp_okay;
        unique case (aw_addr)
          drive_seq_pkg::off_control: begin
            sw_permit <= wv[drive_seq_pkg::ctl_sw_permit];
            plc_permit <= wv[drive_seq_pkg::ctl_plc_permit];
            fault_clr_pulse <= wv[drive_seq_pkg::ctl_fault_clear]; // [R1]
          end
          drive_seq_pkg::off_config: user_sel <= wv[2:0]; // [R5]
          drive_seq_pkg::off_stop_limit: stop_limit <= wv[15:0];
          drive_seq_pkg::off_irq_mask: irq_mask <= wv[ev_w-1:0];
          drive_seq_pkg::off_fault_in: begin
            sw_res_fault <= wv[fault_width-1:0];
            sw_maj_fault <= wv[2*fault_width-1:fault_width];
          end
          drive_seq_pkg::off_irq_status, drive_seq_pkg::off_status: begin
          end
          default: s_axi_bresp <= drive_seq_pkg::resp_slverr;
        endcase
      end
    end
  end

  // sticky events: set wins over write-one-to-clear
  always_comb begin
    next_irq_status = irq_status;
    if (do_write && aw_addr == drive_seq_pkg::off_irq_status && w_strb[0]) begin
      next_irq_status = irq_status & ~w_data[ev_w-1:0];
    end
    next_irq_status = next_irq_status | events;
  end
  assign irq = |(irq_status & irq_mask);

  // axi4-lite read: one cycle after address taken
  logic [31:0] status_word;
  assign status_word = {25'h0, |res_latch, |maj_latch, user_output_contact,
                        health_status_contact, standstill_flag, follow, torque_enable};
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= drive_seq_pkg::resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= drive_seq_pkg::resp_okay;
      unique case (s_axi_araddr)
        drive_seq_pkg::off_control: s_axi_rdata <= ctl_word;
        drive_seq_pkg::off_config: s_axi_rdata <= cfg_word;
        drive_seq_pkg::off_stop_limit: s_axi_rdata <= lim_word;
        drive_seq_pkg::off_status: s_axi_rdata <= status_word;
        drive_seq_pkg::off_irq_status: s_axi_rdata <= {28'h0, irq_status};
        drive_seq_pkg::off_irq_mask: s_axi_rdata <= mask_word;
        drive_seq_pkg::off_fault_in: s_axi_rdata <= flt_word;
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= drive_seq_pkg::resp_slverr;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  a_torque_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    torque_enable |-> (pins.drive_en && sw_permit && plc_permit && pins.bus_ok)) // [R8]
    else $error("torque without full permit");
  a_permit_cut: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(pins.drive_en) |-> !torque_enable) // [R15]
    else $error("hardware permit did not cut torque");
  a_major_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (|maj_latch) |=> (|maj_latch)) // [R3]
    else $error("major fault cleared");
  a_clear_res: assert property (@(posedge aclk) disable iff (!aresetn)
    (clear_req && !(|res_s2) && !(|sw_res_fault)) |=> !(|res_latch)) // [R1]
    else $error("resettable fault not cleared");
  a_health: assert property (@(posedge aclk) disable iff (!aresetn)
    any_fault |=> !health_status_contact) // [R4]
    else $error("health contact closed during fault");
  a_vel_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    !pins.speed_en |=> velocity_cmd == '0) // [R12]
    else $error("velocity not zeroed");
  a_coast_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == drive_seq_pkg::st_braking && rest_s2 && power_permit && pins.bus_ok && !any_fault)
    |=> (standstill_flag && !torque_enable)) // [R13]
    else $error("standstill not flagged");
  a_timeout: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == drive_seq_pkg::st_braking && ms_cnt >= stop_limit) |=> !torque_state) // [R14]
    else $error("stop limit not enforced");
endmodule : drive_enable_stop_sequencer
`default_nettype wire

//--- design/drive_seq_pkg.sv
// package: constants, field layouts and types for the drive enable/stop sequencer
package drive_seq_pkg;
  // register byte offsets
  localparam logic [7:0] off_control = 8'h00; // permits, fault clear
  localparam logic [7:0] off_config = 8'h04; // user output select
  localparam logic [7:0] off_stop_limit = 8'h08; // stop time limit in ms
  localparam logic [7:0] off_status = 8'h0c; // live state, read only
  localparam logic [7:0] off_irq_status = 8'h10; // sticky events, w1c
  localparam logic [7:0] off_irq_mask = 8'h14; // event mask
  localparam logic [7:0] off_fault_in = 8'h18; // fault condition inputs from sw monitors
  // control bit positions
  localparam int ctl_sw_permit = 0; // software permit variable
  localparam int ctl_plc_permit = 1; // plc permit variable over fieldbus
  localparam int ctl_fault_clear = 2; // software fault clear, self clearing
  // status bit positions
  localparam int st_torque = 0;
  localparam int st_vel_follow = 1;
  localparam int st_standstill = 2;
  localparam int st_health = 3;
  localparam int st_user_out = 4;
  localparam int st_major = 5;
  localparam int st_resettable = 6;
  // event bit positions
  localparam int ev_fault = 0;
  localparam int ev_coast = 1;
  localparam int ev_standstill = 2;
  localparam int ev_timeout = 3;
  localparam int ev_width = 4;
  // user output selections
  localparam logic [2:0] sel_health = 3'h0;
  localparam logic [2:0] sel_torque = 3'h1;
  localparam logic [2:0] sel_standstill = 3'h2;
  localparam logic [2:0] sel_vel_follow = 3'h3;
  localparam logic [2:0] sel_any_fault = 3'h4;
  // reset values
  localparam logic [15:0] stop_limit_reset = 16'h03e8; // 1000 ms
  localparam logic [2:0] user_sel_reset = 3'h0;
  // timing: one ms tick at 250 MHz
  localparam int clock_mhz = 250;
  localparam int tick_us = 1000;
  localparam int tick_cycles = tick_us * clock_mhz;
  // axi responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  // stop sequence states
  typedef enum logic [1:0] {st_off, st_run, st_braking, st_free} stop_state_t;
  // synchronised control pins
  typedef struct packed {
    logic drive_en;
    logic speed_en;
    logic fault_clr;
    logic bus_ok;
  } ctrl_pins_t;
endpackage : drive_seq_pkg

//--- design/pin_sync.sv
// two flip-flop synchroniser for a packed group of pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int width = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);
  logic [width-1:0] stage1; // first stage, read only by second stage
  logic [width-1:0] next_stage1;
  logic [width-1:0] next_sync_out;

  // next values: shift one stage per clock
  always_comb begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  // registers, reset low so every permit starts inactive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule : pin_sync
`default_nettype wire

//--- test/controller_plant_model.sv
// controller, power bus and motor model on the far side of the sequencer
`timescale 1ns/10ps
`default_nettype none
module controller_plant_model #(
  parameter int soft_start_len = 20 // bus charge time in cycles
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic want_drive, // bench asks for power permit
  input wire logic want_speed, // bench asks for velocity permit
  input wire logic want_clear, // bench asks for fault clear
  input wire logic bus_drop, // simulated loss of the power bus
  input wire logic stuck, // load that refuses to stop
  input wire logic torque_enable,
  input wire logic [15:0] velocity_cmd,
  output logic drive_enable_pin,
  output logic speed_enable_pin,
  output logic fault_reset_pin,
  output logic bus_voltage_ok,
  output logic motor_at_rest
);
  int charge; // soft start progress
  int speed = 0; // crude motor speed, no reset: rotor keeps moving
  logic charged; // soft start over
  // soft start restarts on every power-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      charge <= 0;
    end else if (charge < soft_start_len) begin
      charge <= charge + 1;
    end
  end
  assign charged = (charge >= soft_start_len);
  assign bus_voltage_ok = charged && !bus_drop;
  // enables are held back until the bus has charged
  assign drive_enable_pin = want_drive && charged;
  assign speed_enable_pin = want_speed && charged;
  assign fault_reset_pin = want_clear;
  // spins up under torque, slows when command is zero or torque is gone
  always_ff @(posedge aclk) begin
    if (torque_enable && velocity_cmd != 16'h0000) begin
      speed <= (speed < 40) ? speed + 1 : speed;
    end else if (speed > 0 && !stuck) begin
      speed <= speed - 1;
    end
  end
  assign motor_at_rest = (speed == 0);
endmodule : controller_plant_model
`default_nettype wire

//--- test/test_drive_enable_stop_sequencer.sv
// self-checking bench for the drive enable and stop sequencer
`timescale 1ns/10ps
`default_nettype none
module test_drive_enable_stop_sequencer;
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hit_a, hit_w;
  logic drive_enable_pin, speed_enable_pin, fault_reset_pin, bus_voltage_ok, motor_at_rest;
  logic [7:0] resettable_cause, major_cause; // live fault causes
  logic [15:0] velocity_cmd_in, velocity_cmd;
  logic torque_enable, health_status_contact, user_output_contact, standstill_flag, irq;
  logic want_drive, want_speed, want_clear, bus_drop, stuck; // model requests
  int err_count, comparisons, n;
  // short ms tick keeps stop times small
  drive_enable_stop_sequencer #(.tick_len(4)) drive_enable_stop_sequencer_inst (.*);
  controller_plant_model controller_plant_model_inst (.*);
  // 250 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  function automatic logic [31:0] bitv(input int p);
    return 32'h1 << p;
  endfunction : bitv
  // shared comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk
  // let edges pass, end between edges where outputs are settled
  task automatic settle(input int c);
    repeat (c) @(posedge aclk);
    @(negedge aclk);
  endtask : settle
  // axi write: address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(negedge aclk);
    while (s_axi_awvalid || s_axi_wvalid) begin
      hit_a = s_axi_awready;
      hit_w = s_axi_wready;
      @(posedge aclk);
      if (hit_a) s_axi_awvalid <= 1'b0;
      if (hit_w) s_axi_wvalid <= 1'b0;
      @(negedge aclk);
    end
    while (!s_axi_bvalid) @(negedge aclk);
    rsp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : axi_write
  // axi read, data and response taken at the handshake edge
  task automatic axi_read(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(negedge aclk);
    while (s_axi_arvalid) begin
      hit_a = s_axi_arready;
      @(posedge aclk);
      if (hit_a) s_axi_arvalid <= 1'b0;
      @(negedge aclk);
    end
    while (!s_axi_rvalid) @(negedge aclk);
    rd_data = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask : axi_read
  // masked register compare plus okay response
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axi_read(a);
    chk(rd_data & m, e);
    chk({30'h0, rsp}, {30'h0, drive_seq_pkg::resp_okay});
  endtask : rd
  task automatic pins(input logic d, input logic s);
    @(posedge aclk);
    want_drive <= d;
    want_speed <= s;
  endtask : pins
  // fault clear held high for a few cycles
  task automatic clr;
    @(posedge aclk);
    want_clear <= 1'b1;
    repeat (8) @(posedge aclk);
    want_clear <= 1'b0;
    settle(4);
  endtask : clr
  // from off: permits set, drive first, then speed, motor spun up
  task automatic rearm;
    pins(1'b0, 1'b0);
    axi_write(drive_seq_pkg::off_control, 32'h3); // sw and plc permits
    settle(4);
    pins(1'b1, 1'b0);
    settle(4);
    pins(1'b1, 1'b1);
    settle(50);
  endtask : rearm
  task automatic report_and_stop;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  // watchdog: whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    report_and_stop();
  end
  initial begin
    {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, want_drive, want_speed, want_clear} = '0;
    {bus_drop, stuck, resettable_cause, major_cause} = '0;
    s_axi_wstrb = 4'hf;
    velocity_cmd_in = 16'h0123;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    settle(30);
    chk(health_status_contact, 32'h1);
    chk(torque_enable, 32'h0);
    rd(drive_seq_pkg::off_stop_limit, 32'hffff, {16'h0, drive_seq_pkg::stop_limit_reset});
    axi_read(8'h1c); // unmapped place
    chk({30'h0, rsp}, {30'h0, drive_seq_pkg::resp_slverr});
    chk(rd_data, 32'h0);
    // speed permit first, then power permit
    axi_write(drive_seq_pkg::off_control, 32'h3);
    pins(1'b0, 1'b1);
    settle(8);
    chk(torque_enable, 32'h0);
    chk(velocity_cmd, 32'h0);
    pins(1'b1, 1'b1);
    settle(8);
    chk(torque_enable, 32'h1);
    chk(velocity_cmd, 32'h0123);
    @(posedge aclk);
    velocity_cmd_in <= 16'h0456;
    settle(4);
    chk(velocity_cmd, 32'h0456);
    rd(drive_seq_pkg::off_status, 32'h3, 32'h3);
    // software and plc permits withdrawn alone, then the bus dropped
    axi_write(drive_seq_pkg::off_control, 32'h2);
    settle(4);
    chk(torque_enable, 32'h0);
    rearm();
    chk(torque_enable, 32'h1);
    axi_write(drive_seq_pkg::off_control, 32'h1);
    settle(4);
    chk(torque_enable, 32'h0);
    rearm();
    @(posedge aclk);
    bus_drop <= 1'b1;
    settle(6);
    chk(torque_enable, 32'h0);
    @(posedge aclk);
    bus_drop <= 1'b0;
    // hardware permit loss with software permits still set
    rearm();
    axi_write(drive_seq_pkg::off_irq_status, 32'hf);
    pins(1'b0, 1'b1);
    n = 0;
    while (torque_enable !== 1'b0 && n < 20) begin
      @(negedge aclk);
      n++;
    end
    chk({31'h0, n <= 4}, 32'h1);
    rd(drive_seq_pkg::off_irq_status, bitv(1), bitv(1));
    chk(irq, 32'h0);
    axi_write(drive_seq_pkg::off_irq_mask, bitv(drive_seq_pkg::ev_coast));
    settle(2);
    chk(irq, 32'h1);
    axi_write(drive_seq_pkg::off_irq_status, bitv(drive_seq_pkg::ev_coast));
    settle(2);
    chk(irq, 32'h0);
    // velocity permit stop reaching standstill in time
    rearm();
    axi_write(drive_seq_pkg::off_irq_status, 32'hf);
    pins(1'b1, 1'b0);
    settle(6);
    chk(torque_enable, 32'h1);
    chk(velocity_cmd, 32'h0);
    n = 0;
    while (standstill_flag !== 1'b1 && n < 200) begin
      @(negedge aclk);
      n++;
    end
    settle(4);
    chk(standstill_flag, 32'h1);
    chk(torque_enable, 32'h0);
    rd(drive_seq_pkg::off_irq_status, bitv(2), bitv(2));
    // load never stops: 2 ms limit of 4 cycles each
    axi_write(drive_seq_pkg::off_stop_limit, 32'h2);
    @(posedge aclk);
    stuck <= 1'b1;
    rearm();
    pins(1'b1, 1'b0);
    n = 0;
    while (torque_enable !== 1'b0 && n < 100) begin
      @(negedge aclk);
      n++;
    end
    chk({31'h0, n >= 8 && n <= 20}, 32'h1);
    chk(standstill_flag, 32'h0);
    rd(drive_seq_pkg::off_irq_status, bitv(3), bitv(3));
    @(posedge aclk);
    stuck <= 1'b0;
    // user output for every selection while running healthy
    rearm();
    for (int i = 0; i < 6; i++) begin
      axi_write(drive_seq_pkg::off_config, i);
      settle(3);
      chk(user_output_contact, (32'h2b >> i) & 32'h1);
    end
    // resettable fault: cause held, then removed
    @(posedge aclk);
    resettable_cause <= 8'h01;
    settle(6);
    chk(health_status_contact, 32'h0);
    chk(user_output_contact, 32'h0);
    clr();
    chk(health_status_contact, 32'h0);
    rd(drive_seq_pkg::off_status, bitv(6), bitv(6));
    @(posedge aclk);
    resettable_cause <= 8'h00;
    clr();
    chk(health_status_contact, 32'h1);
    // major fault survives clear, goes only with power cycle
    @(posedge aclk);
    major_cause <= 8'h01;
    settle(6);
    @(posedge aclk);
    major_cause <= 8'h00;
    clr();
    chk(health_status_contact, 32'h0);
    rd(drive_seq_pkg::off_status, bitv(5), bitv(5));
    pins(1'b0, 1'b0);
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    settle(30);
    chk(health_status_contact, 32'h1);
    report_and_stop();
  end
endmodule : test_drive_enable_stop_sequencer
`default_nettype wire
